// file: shared/fosr_link_if.sv
`timescale 1ns/100ps
// ==========================================
// Internal links: bus slave, register core, pin gate
interface fosr_link_if;
    logic       bus_wr;
    logic [7:0] bus_idx;
    logic [7:0] bus_wdata;
    logic [7:0] bus_rdata;
    logic [1:0] mc_ovr;
    logic       wp_ovr0;

    modport bus  (output bus_wr, bus_idx, bus_wdata, input bus_rdata);
    modport regs (input bus_wr, bus_idx, bus_wdata, output bus_rdata, mc_ovr, wp_ovr0);
    modport gate (input mc_ovr, wp_ovr0);
endinterface

// file: shared/fosr_pkg.sv
// ==========================================
// Register map and field layouts
package fosr_pkg;

    // Bus geometry
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int BE_W   = 4;

    // Register indices, byte address is four times the index
    localparam logic [7:0] IDX_MC_OVR = 8'hC1;
    localparam logic [7:0] IDX_RATE   = 8'hC2;
    localparam logic [7:0] IDX_SER1   = 8'hC3;
    localparam logic [7:0] IDX_SER2   = 8'hC4;
    localparam logic [7:0] IDX_WP_OVR = 8'hC5;

    // Reset values
    localparam logic [1:0] MC_OVR_RST = 2'h3;
    localparam logic       WP_OVR_RST = 1'b0;
    localparam logic [7:0] MIRROR_RST = 8'h00;
    localparam logic       PIN_RST    = 1'b1;

    // Override bit positions
    localparam int MC_DRV0_BIT = 0;
    localparam int MC_DRV1_BIT = 1;
    localparam int WP_DRV0_BIT = 0;

    // Data-rate select layout, bit 7 down to bit 0
    typedef struct packed {
        logic soft_reset;
        logic power_down;
        logic rsvd5;
        logic precomp_sel2;
        logic precomp_sel1;
        logic precomp_sel0;
        logic [1:0] rate_sel;
    } fosr_rate_s;

    // Serial FIFO control layout, bit 7 down to bit 0
    typedef struct packed {
        logic       rx_threshold_hi;
        logic       rx_threshold_lo;
        logic [1:0] rsvd;
        logic       dma_mode;
        logic       tx_queue_flush;
        logic       rx_queue_flush;
        logic       fifo_enable;
    } fosr_fifo_s;

endpackage

// file: verif/fosr_core_model.sv
`timescale 1ns/100ps
// ==========================================
// Core side: writes to the write-only registers
module fosr_core_model (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    // Command from the bench
    input  wire logic       cmd_valid_i,
    input  wire logic [1:0] cmd_sel_i,
    input  wire logic [7:0] cmd_data_i,
    // Strobes and shared data toward the mirrors
    output logic            rate_wr_o,
    output logic            ser1_wr_o,
    output logic            ser2_wr_o,
    output logic [7:0]      data_o
);
    // One-cycle strobe; data line scrambled whenever no command is valid
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rate_wr_o <= 1'b0;
            ser1_wr_o <= 1'b0;
            ser2_wr_o <= 1'b0;
            data_o    <= 8'h5A;
        end else begin
            rate_wr_o <= cmd_valid_i && (cmd_sel_i == 2'h0);
            ser1_wr_o <= cmd_valid_i && (cmd_sel_i == 2'h1);
            ser2_wr_o <= cmd_valid_i && (cmd_sel_i == 2'h2);
            data_o    <= cmd_valid_i ? cmd_data_i : ~data_o;
        end
    end
endmodule

// file: verif/tb.sv
`timescale 1ns/100ps
// ==========================================
// Bench for the override and mirror register group
module tb;
    logic                        clk_i;
    logic                        sys_rst_i;
    logic [fosr_pkg::ADDR_W-1:0] avs_address_i;
    logic                        avs_read_i;
    logic                        avs_write_i;
    logic [fosr_pkg::DATA_W-1:0] avs_writedata_i;
    logic [3:0]                  be;
    logic [fosr_pkg::DATA_W-1:0] avs_readdata_o;
    logic                        avs_waitrequest_o;
    logic                        step_n, ds0_n, ds1_n, dc_n, wp_n, pp_n;
    logic                        cmd_valid;
    logic [1:0]                  cmd_sel;
    logic [7:0]                  cmd_data;
    logic                        rate_wr, ser1_wr, ser2_wr;
    logic [7:0]                  core_data;
    logic                        dc_o, wp_o, pp_o;
    logic [31:0]                 rd;
    int                          n_errors;
    int                          samples_checked;

    // ==========================================
    // Design and core-side model
    fosr_regs_top u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(be), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .head_step_n_i(step_n), .drive0_select_n_i(ds0_n), .drive1_select_n_i(ds1_n),
        .disk_changed_in_n_i(dc_n), .write_protect_in_n_i(wp_n), .pp_write_protect_in_n_i(pp_n),
        .rate_sel_wr_i(rate_wr), .rate_sel_data_i(core_data), .serial1_fifo_ctl_wr_i(ser1_wr),
        .serial1_fifo_ctl_data_i(core_data), .serial2_fifo_ctl_wr_i(ser2_wr),
        .serial2_fifo_ctl_data_i(core_data), .disk_changed_status_o(dc_o),
        .write_protect_core_n_o(wp_o), .pp_write_protect_core_n_o(pp_o));
    fosr_core_model u_core (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cmd_valid_i(cmd_valid),
        .cmd_sel_i(cmd_sel), .cmd_data_i(cmd_data), .rate_wr_o(rate_wr), .ser1_wr_o(ser1_wr),
        .ser2_wr_o(ser2_wr), .data_o(core_data));

    // ==========================================
    // Checking and closing
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task finish_test();
        $display("Checks %0d, errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ==========================================
    // Avalon-MM master
    task wait_ack(output logic [31:0] d);
        int i;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (avs_waitrequest_o === 1'b0) break;
        end
        if (i == 20) begin
            n_errors++;
            $display("[FAIL] waitrequest never dropped");
            finish_test();
        end else begin
            d = avs_readdata_o;
            avs_read_i  <= 1'b0;
            avs_write_i <= 1'b0;
        end
    endtask

    task bus_rd(input logic [7:0] idx, output logic [31:0] d);
        @(posedge clk_i);
        avs_address_i <= {idx, 2'b00};
        avs_read_i    <= 1'b1;
        wait_ack(d);
    endtask

    task bus_wr(input logic [7:0] idx, input logic [7:0] v);
        logic [31:0] d;
        @(posedge clk_i);
        avs_address_i   <= {idx, 2'b00};
        avs_writedata_i <= {24'h000000, v};
        avs_write_i     <= 1'b1;
        wait_ack(d);
    endtask

    task rd_chk(input string what, input logic [7:0] idx, input logic [31:0] exp);
        bus_rd(idx, rd);
        check(what, rd, exp);
    endtask

    // ==========================================
    // Drive pins and gated output sweeps
    task set_pins(input logic d0, input logic d1, input logic dc, input logic wp, input logic pp,
                  input logic st);
        @(posedge clk_i);
        ds0_n  <= d0;
        ds1_n  <= d1;
        dc_n   <= dc;
        wp_n   <= wp;
        pp_n   <= pp;
        step_n <= st;
        repeat (2) @(posedge clk_i);
    endtask

    task dc_sweep(input logic [1:0] ovr);
        logic [2:0] k;
        for (int j = 0; j < 8; j++) begin
            k = j[2:0];
            set_pins(k[0], k[1], k[2], 1'b1, 1'b1, 1'b0);
            check("disk_changed_status", {31'h0, dc_o}, {31'h0, (k[0] & ovr[0]) | (k[1] & ovr[1]) | k[2]});
        end
    endtask

    task wp_sweep(input logic ovr);
        logic [2:0] k;
        for (int j = 0; j < 8; j++) begin
            k = j[2:0];
            set_pins(k[0], 1'b0, 1'b0, k[1], k[2], 1'b0);
            check("write_protect_core_n", {31'h0, wp_o}, {31'h0, (k[0] & ovr) | k[1]});
            check("pp_write_protect_core_n", {31'h0, pp_o}, {31'h0, (k[0] & ovr) | k[2]});
        end
    endtask

    // Clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // Main sequence
    initial begin
        {avs_read_i, avs_write_i, step_n, ds0_n, ds1_n, dc_n, cmd_valid} = 7'h00;
        {wp_n, pp_n} = 2'h3;
        avs_address_i = '0;
        avs_writedata_i = '0;
        be = 4'hF;
        cmd_sel = 2'h0;
        cmd_data = 8'h00;
        n_errors = 0;
        samples_checked = 0;
        sys_rst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd_chk("media_change_override", 8'hC1, 32'h03);
        rd_chk("write_protect_override", 8'hC5, 32'h00);
        for (int m = 0; m < 3; m++) rd_chk("mirror reset", 8'hC2 + m[7:0], 32'h00);
        rd_chk("unmapped", 8'hC6, 32'h00);
        dc_sweep(2'h3);
        set_pins(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
        rd_chk("drive1 cleared", 8'hC1, 32'h01);
        set_pins(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
        rd_chk("drive0 cleared", 8'hC1, 32'h00);
        dc_sweep(2'h0);
        bus_wr(8'hC1, 8'h02);
        rd_chk("set bit1", 8'hC1, 32'h02);
        bus_wr(8'hC1, 8'h00);
        rd_chk("zero write keeps", 8'hC1, 32'h02);
        dc_sweep(2'h2);
        bus_wr(8'hC1, 8'hFF);
        rd_chk("reserved bits", 8'hC1, 32'h03);
        set_pins(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
        rd_chk("both cleared", 8'hC1, 32'h00);
        bus_wr(8'hC1, 8'h03);
        step_n <= 1'b0;
        rd_chk("set beats clear", 8'hC1, 32'h03);
        bus_wr(8'hC5, 8'hFF);
        rd_chk("wp reserved", 8'hC5, 32'h01);
        wp_sweep(1'b1);
        bus_wr(8'hC5, 8'h00);
        rd_chk("wp cleared", 8'hC5, 32'h00);
        // Write with low byte lane disabled is ignored
        be <= 4'h0;
        bus_wr(8'hC5, 8'h01);
        be <= 4'hF;
        rd_chk("wp masked write", 8'hC5, 32'h00);
        wp_sweep(1'b0);
        // Back-to-back core writes into the three mirrors
        for (int m = 0; m < 3; m++) begin
            @(posedge clk_i);
            cmd_valid <= 1'b1;
            cmd_sel   <= m[1:0];
            cmd_data  <= (m == 2) ? 8'hA5 : 8'hFF;
        end
        @(posedge clk_i);
        cmd_valid <= 1'b0;
        repeat (2) @(posedge clk_i);
        bus_wr(8'hC2, 8'h00);
        bus_wr(8'hC3, 8'h00);
        rd_chk("rate mirror", 8'hC2, 32'hDF);
        rd_chk("serial1 mirror", 8'hC3, 32'hCF);
        rd_chk("serial2 mirror", 8'hC4, 32'h85);
        finish_test();
    end
endmodule

// file: verilog/fosr_avs_slave.sv
`timescale 1ns/100ps
// ==========================================
// Avalon-MM slave with one wait cycle
module fosr_avs_slave (
    // Clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         sys_rst_i,
    // Avalon-MM
    input  wire logic [fosr_pkg::ADDR_W-1:0]  avs_address_i,
    input  wire logic                         avs_read_i,
    input  wire logic                         avs_write_i,
    input  wire logic [fosr_pkg::DATA_W-1:0]  avs_writedata_i,
    input  wire logic [fosr_pkg::BE_W-1:0]    avs_byteenable_i,
    output logic      [fosr_pkg::DATA_W-1:0]  avs_readdata_o,
    output logic                              avs_waitrequest_o,
    // Register side
    fosr_link_if.bus                          lnk
);
    typedef struct packed {
        logic                        waitreq;
        logic [fosr_pkg::DATA_W-1:0] rdata;
    } fosr_avs_s;

    fosr_avs_s st_reg;
    fosr_avs_s st_next;
    logic      req;
    logic      aligned;

    // Decode and write strobe on the completing edge
    assign req           = avs_read_i | avs_write_i;
    assign aligned       = (avs_address_i[1:0] == 2'h0);
    assign lnk.bus_idx   = avs_address_i[fosr_pkg::ADDR_W-1:2];
    assign lnk.bus_wdata = avs_writedata_i[7:0];
    assign lnk.bus_wr    = avs_write_i & ~st_reg.waitreq & aligned & avs_byteenable_i[0];

    // First cycle fetches data, second cycle completes
    always_comb begin
        st_next         = st_reg;
        st_next.waitreq = 1'b1;
        if (req && st_reg.waitreq) begin
            st_next.waitreq = 1'b0;
            st_next.rdata   = '0;
            if (avs_read_i && aligned) begin
                st_next.rdata = {24'h000000, lnk.bus_rdata};
            end
        end
    end

    // State register
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_reg <= '{waitreq: 1'b1, rdata: 32'h00000000};
        end else begin
            st_reg <= st_next;
        end
    end

    assign avs_readdata_o    = st_reg.rdata;
    assign avs_waitrequest_o = st_reg.waitreq;
endmodule

// file: verilog/fosr_pin_gate.sv
`timescale 1ns/100ps
// ==========================================
// Registered override gating of drive signals
module fosr_pin_gate (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    // Drive interface
    input  wire logic drive0_select_n_i,
    input  wire logic drive1_select_n_i,
    input  wire logic disk_changed_in_n_i,
    input  wire logic write_protect_in_n_i,
    input  wire logic pp_write_protect_in_n_i,
    // Override bits
    fosr_link_if.gate lnk,
    // To controller core
    output logic      disk_changed_status_o,
    output logic      write_protect_core_n_o,
    output logic      pp_write_protect_core_n_o
);
    typedef struct packed {
        logic dsk;
        logic wp;
        logic pp_wp;
    } fosr_gate_s;

    fosr_gate_s st_reg;
    fosr_gate_s st_next;

    // Combine drive selects with override bits
    always_comb begin
        st_next.dsk   = (drive0_select_n_i & lnk.mc_ovr[fosr_pkg::MC_DRV0_BIT])
                      | (drive1_select_n_i & lnk.mc_ovr[fosr_pkg::MC_DRV1_BIT])
                      | disk_changed_in_n_i;
        st_next.wp    = (drive0_select_n_i & lnk.wp_ovr0) | write_protect_in_n_i;
        st_next.pp_wp = (drive0_select_n_i & lnk.wp_ovr0) | pp_write_protect_in_n_i;
    end

    // State register
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_reg <= {3{fosr_pkg::PIN_RST}};
        end else begin
            st_reg <= st_next;
        end
    end

    assign disk_changed_status_o     = st_reg.dsk;
    assign write_protect_core_n_o    = st_reg.wp;
    assign pp_write_protect_core_n_o = st_reg.pp_wp;
endmodule

// file: verilog/fosr_regs_top.sv
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
// ==========================================
// Drive override and shadow register group

module fosr_regs_top (
    // Clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         sys_rst_i,
    // Avalon-MM slave
    input  wire logic [fosr_pkg::ADDR_W-1:0]  avs_address_i,
    input  wire logic                         avs_read_i,
    input  wire logic                         avs_write_i,
    input  wire logic [fosr_pkg::DATA_W-1:0]  avs_writedata_i,
    input  wire logic [fosr_pkg::BE_W-1:0]    avs_byteenable_i,
    output logic      [fosr_pkg::DATA_W-1:0]  avs_readdata_o,
    output logic                              avs_waitrequest_o,
    // Drive interface
    input  wire logic                         head_step_n_i,
    input  wire logic                         drive0_select_n_i,
    input  wire logic                         drive1_select_n_i,
    input  wire logic                         disk_changed_in_n_i,
    input  wire logic                         write_protect_in_n_i,
    input  wire logic                         pp_write_protect_in_n_i,
    // Writes seen by the write-only registers
    input  wire logic                         rate_sel_wr_i,
    input  wire logic [7:0]                   rate_sel_data_i,
    input  wire logic                         serial1_fifo_ctl_wr_i,
    input  wire logic [7:0]                   serial1_fifo_ctl_data_i,
    input  wire logic                         serial2_fifo_ctl_wr_i,
    input  wire logic [7:0]                   serial2_fifo_ctl_data_i,
    // To controller core
    output logic                              disk_changed_status_o,
    output logic                              write_protect_core_n_o,
    output logic                              pp_write_protect_core_n_o
);

    // ==========================================
    // State

    typedef struct packed {
        logic [1:0]          mc_ovr;
        logic                wp_ovr0;
        fosr_pkg::fosr_rate_s rate_mirror;
        fosr_pkg::fosr_fifo_s ser1_mirror;
        fosr_pkg::fosr_fifo_s ser2_mirror;
    } fosr_regs_s;

    fosr_regs_s st_reg;
    fosr_regs_s st_next;
    logic       clr0;
    logic       clr1;
    logic       mc_wr;
    logic       wp_wr;

    fosr_link_if lnk ();

    // ==========================================
    // Field cleaning

    // Reserved rate bit forced low
    function automatic fosr_pkg::fosr_rate_s fosr_rate_clean(input logic [7:0] b);
        fosr_pkg::fosr_rate_s r;
        r       = fosr_pkg::fosr_rate_s'(b);
        r.rsvd5 = 1'b0;
        return r;
    endfunction

    // Reserved FIFO control bits forced low
    function automatic fosr_pkg::fosr_fifo_s fosr_fifo_clean(input logic [7:0] b);
        fosr_pkg::fosr_fifo_s f;
        f      = fosr_pkg::fosr_fifo_s'(b);
        f.rsvd = 2'h0;
        return f;
    endfunction

    // ==========================================
    // Bus slave

    fosr_avs_slave u_avs (
        .clk_i             (clk_i),
        .sys_rst_i         (sys_rst_i),
        .avs_address_i     (avs_address_i),
        .avs_read_i        (avs_read_i),
        .avs_write_i       (avs_write_i),
        .avs_writedata_i   (avs_writedata_i),
        .avs_byteenable_i  (avs_byteenable_i),
        .avs_readdata_o    (avs_readdata_o),
        .avs_waitrequest_o (avs_waitrequest_o),
        .lnk               (lnk.bus)
    );

    // ==========================================
    // Register update

    // Hardware clear terms and write decodes
    assign clr0  = head_step_n_i & drive0_select_n_i;
    assign clr1  = head_step_n_i & drive1_select_n_i;
    assign mc_wr = lnk.bus_wr && (lnk.bus_idx == fosr_pkg::IDX_MC_OVR);
    assign wp_wr = lnk.bus_wr && (lnk.bus_idx == fosr_pkg::IDX_WP_OVR);

    // Next state of all registers
    always_comb begin
        st_next = st_reg;
        // Clear first, then set so a write of 1 wins
        if (clr0) begin
            st_next.mc_ovr[fosr_pkg::MC_DRV0_BIT] = 1'b0;
        end
        if (clr1) begin
            st_next.mc_ovr[fosr_pkg::MC_DRV1_BIT] = 1'b0;
        end
        if (mc_wr) begin
            st_next.mc_ovr = st_next.mc_ovr | lnk.bus_wdata[1:0];
        end
        // Plain read-write override
        if (wp_wr) begin
            st_next.wp_ovr0 = lnk.bus_wdata[fosr_pkg::WP_DRV0_BIT];
        end
        // Mirrors follow the core's writes only
        if (rate_sel_wr_i) begin
            st_next.rate_mirror = fosr_rate_clean(rate_sel_data_i);
        end
        if (serial1_fifo_ctl_wr_i) begin
            st_next.ser1_mirror = fosr_fifo_clean(serial1_fifo_ctl_data_i);
        end
        if (serial2_fifo_ctl_wr_i) begin
            st_next.ser2_mirror = fosr_fifo_clean(serial2_fifo_ctl_data_i);
        end
    end

    // State register
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_reg.mc_ovr      <= fosr_pkg::MC_OVR_RST;
            st_reg.wp_ovr0     <= fosr_pkg::WP_OVR_RST;
            st_reg.rate_mirror <= fosr_pkg::MIRROR_RST;
            st_reg.ser1_mirror <= fosr_pkg::MIRROR_RST;
            st_reg.ser2_mirror <= fosr_pkg::MIRROR_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign lnk.mc_ovr  = st_reg.mc_ovr;
    assign lnk.wp_ovr0 = st_reg.wp_ovr0;

    // ==========================================
    // Read mux

    // Unmapped indices read zero
    always_comb begin
        lnk.bus_rdata = 8'h00;
        case (lnk.bus_idx)
            fosr_pkg::IDX_MC_OVR: begin
                lnk.bus_rdata = {6'h00, st_reg.mc_ovr};
            end
            fosr_pkg::IDX_RATE: begin
                lnk.bus_rdata = st_reg.rate_mirror;
            end
            fosr_pkg::IDX_SER1: begin
                lnk.bus_rdata = st_reg.ser1_mirror;
            end
            fosr_pkg::IDX_SER2: begin
                lnk.bus_rdata = st_reg.ser2_mirror;
            end
            fosr_pkg::IDX_WP_OVR: begin
                lnk.bus_rdata = {7'h00, st_reg.wp_ovr0};
            end
            default: begin
                lnk.bus_rdata = 8'h00;
            end
        endcase
    end

    // ==========================================
    // Drive signal gating

    // Override bits steer disk change and write protect
    fosr_pin_gate u_gate (
        .clk_i                     (clk_i),
        .sys_rst_i                 (sys_rst_i),
        .drive0_select_n_i         (drive0_select_n_i),
        .drive1_select_n_i         (drive1_select_n_i),
        .disk_changed_in_n_i       (disk_changed_in_n_i),
        .write_protect_in_n_i      (write_protect_in_n_i),
        .pp_write_protect_in_n_i   (pp_write_protect_in_n_i),
        .lnk                       (lnk.gate),
        .disk_changed_status_o     (disk_changed_status_o),
        .write_protect_core_n_o    (write_protect_core_n_o),
        .pp_write_protect_core_n_o (pp_write_protect_core_n_o)
    );

    // ==========================================
    // Assertions

    // Write of 1 sets drive-0 override even against a clear
    AST_MC0_SET: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        mc_wr && lnk.bus_wdata[0] |=> st_reg.mc_ovr[0])
        else $error("drive0 override not set by write");

    // Set drive-1 bit survives any software write without its clear term
    AST_MC_NO_SW_CLR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        st_reg.mc_ovr[1] && !clr1 |=> st_reg.mc_ovr[1])
        else $error("drive1 override lost without hardware clear");

    // Drive-1 clear term empties the bit
    AST_MC1_CLR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        clr1 && !(mc_wr && lnk.bus_wdata[1]) |=> !st_reg.mc_ovr[1])
        else $error("drive1 override not cleared");

    // Drive-0 clear term empties the bit
    AST_MC0_CLR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        clr0 && !(mc_wr && lnk.bus_wdata[0]) |=> !st_reg.mc_ovr[0])
        else $error("drive0 override not cleared");

    // Status output one cycle behind its inputs
    AST_DSK_STATUS: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !$past(sys_rst_i) |-> disk_changed_status_o ==
            (($past(drive0_select_n_i) & $past(st_reg.mc_ovr[0]))
           | ($past(drive1_select_n_i) & $past(st_reg.mc_ovr[1]))
           | $past(disk_changed_in_n_i)))
        else $error("disk change status mismatch");

    // Drive-1 override alone drives status while selected
    AST_DSK_DRV1: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        drive1_select_n_i && st_reg.mc_ovr[1] |=> disk_changed_status_o)
        else $error("drive1 override has no effect");

    // Reserved override bits read zero
    AST_MC_RSVD: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        lnk.bus_idx == fosr_pkg::IDX_MC_OVR |-> lnk.bus_rdata[7:2] == 6'h00)
        else $error("override reserved bits nonzero");

    // Rate mirror holds the captured byte with bit 5 low
    AST_RATE_MIRROR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        rate_sel_wr_i |=> st_reg.rate_mirror == ($past(rate_sel_data_i) & 8'hDF))
        else $error("rate mirror mismatch");

    // First serial mirror with bits 5:4 low
    AST_SER1_MIRROR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        serial1_fifo_ctl_wr_i |=> st_reg.ser1_mirror == ($past(serial1_fifo_ctl_data_i) & 8'hCF))
        else $error("serial1 mirror mismatch");

    // Second serial mirror with bits 5:4 low
    AST_SER2_MIRROR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        serial2_fifo_ctl_wr_i |=> st_reg.ser2_mirror == ($past(serial2_fifo_ctl_data_i) & 8'hCF))
        else $error("serial2 mirror mismatch");

    // Core write protect follows override and drive input
    AST_WP_CORE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !$past(sys_rst_i) |-> write_protect_core_n_o ==
            (($past(drive0_select_n_i) & $past(st_reg.wp_ovr0)) | $past(write_protect_in_n_i)))
        else $error("core write protect mismatch");

    // Override forces write protect while drive 0 selected
    AST_WP_FORCE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        drive0_select_n_i && st_reg.wp_ovr0 |=> write_protect_core_n_o)
        else $error("write protect override has no effect");

    // Parallel-port path follows the same override
    AST_PP_WP: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !$past(sys_rst_i) |-> pp_write_protect_core_n_o ==
            (($past(drive0_select_n_i) & $past(st_reg.wp_ovr0)) | $past(pp_write_protect_in_n_i)))
        else $error("parallel port write protect mismatch");

    // Write-protect override reserved bits read zero
    AST_WP_RSVD: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        lnk.bus_idx == fosr_pkg::IDX_WP_OVR |-> lnk.bus_rdata[7:1] == 7'h00)
        else $error("write protect reserved bits nonzero");

    // Bus writes to the rate index leave the rate mirror untouched
    AST_MIRROR_RO: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        lnk.bus_wr && (lnk.bus_idx == fosr_pkg::IDX_RATE) && !rate_sel_wr_i
        |=> $stable(st_reg.rate_mirror))
        else $error("rate mirror changed by bus write");

endmodule
